// >>> src/rpm_pkg.sv
// Shared definitions of the two-wire register port master: link timing,
// slave address, sequencer states and the command and answer carriers.
// Assumes a 100 MHz system clock and a 400 kHz serial clock.
package rpm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SCL_PERIOD_NS = 2500;
    // A quarter bit is rounded up, so no clock phase is ever too short.
    localparam int unsigned QTR_CYC =
        (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int unsigned REG_W = 16;
    localparam int unsigned NW_W  = 4;
    localparam logic [5:0] DEV_ADDR_HI = 6'h0D;
    localparam logic       RW_WR       = 1'h0;
    localparam logic       RW_RD       = 1'h1;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam logic [NW_W-1:0] NW_ONE = 4'h1;
    localparam logic [7:0] PTR_STEP    = 8'h01;
    localparam logic [1:0] PH_FALL     = 2'h0;
    localparam logic [1:0] PH_SET      = 2'h1;
    localparam logic [1:0] PH_RISE     = 2'h2;
    localparam logic [1:0] PH_HIGH     = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_ADDR_W, ST_REG, ST_RSTART, ST_ADDR_R,
        ST_WR_HI, ST_WR_LO, ST_RD_HI, ST_RD_LO, ST_STOP
    } rpm_state_e;

    typedef struct packed {
        logic            rd;
        logic [7:0]      reg_addr;
        logic [NW_W-1:0] nwords;
    } rpm_cmd_s;

    typedef struct packed {
        logic [7:0]       reg_addr;
        logic [REG_W-1:0] data;
    } rpm_rsp_s;
endpackage

// >>> src/rpm_sync.sv
// Two-stage synchroniser for levels arriving from the serial pins.
// Assumes the inputs are asynchronous to clk and reset is synchronous.
`timescale 1ns/1ps
module rpm_sync #(
    parameter int unsigned W       = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset.
    input  logic         clk,
    input  logic         rst_b,
    // Levels.
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // rpm_sync

// >>> src/rpm_master.sv
// Two-wire bus master that writes and reads the 16-bit registers of the
// codec's serial slave port, generating the serial clock by a divider.
// Assumes pull-ups on both lines and a testbench resolving the open drains.
`timescale 1ns/1ps
module rpm_master
    import rpm_pkg::*;
#(
    parameter int unsigned QTR = QTR_CYC
) (
    // Clock and reset.
    input  logic             ref_clk,
    input  logic             rst_b,
    // Command.
    input  logic             cmd_valid,
    input  rpm_cmd_s         cmd,
    input  logic             slave_addr_low_bit,
    output logic             cmd_ready,
    // Write words.
    input  logic             wr_valid,
    input  logic [REG_W-1:0] wr_data,
    output logic             wr_ready,
    // Read words and completion.
    output logic             rd_valid,
    output rpm_rsp_s         rd_word,
    output logic             done,
    output logic             nack_err,
    // Serial pins.
    input  logic             scl_i,
    output logic             scl_o,
    output logic             scl_oe_b,
    input  logic             sda_i,
    output logic             sda_o,
    output logic             sda_oe_b
);
    localparam int unsigned QW = $clog2(QTR);

    function automatic logic is_byte_st(input rpm_state_e s);
        return !(s inside {ST_IDLE, ST_START, ST_RSTART, ST_STOP});
    endfunction

    function automatic logic is_rd_st(input rpm_state_e s);
        return s inside {ST_RD_HI, ST_RD_LO};
    endfunction

    function automatic logic [7:0] byte_of(input rpm_state_e s, input logic lb,
                                           input logic [7:0] p,
                                           input logic [REG_W-1:0] w);
        case (s)
            ST_ADDR_W: return {DEV_ADDR_HI, lb, RW_WR};
            ST_ADDR_R: return {DEV_ADDR_HI, lb, RW_RD};
            ST_REG:    return p;
            ST_WR_HI:  return w[15:8];
            ST_WR_LO:  return w[7:0];
            default:   return 8'hFF;
        endcase
    endfunction

    rpm_state_e       st_ff;
    rpm_state_e       nxt_st;
    logic [QW-1:0]    qcnt_ff;
    logic [1:0]       ph_ff;
    logic [3:0]       bitn_ff;
    logic [7:0]       txb_ff;
    logic [7:0]       rxb_ff;
    logic             ack_ff;
    logic             err_ff;
    logic [7:0]       ptr_ff;
    logic [NW_W-1:0]  left_ff;
    logic             rd_ff;
    logic             low_bit_ff;
    logic [REG_W-1:0] word_ff;
    logic             have_word_ff;
    logic             cmd_ready_ff;
    logic             wr_ready_ff;
    logic             rd_valid_ff;
    rpm_rsp_s         rd_word_ff;
    logic             done_ff;
    logic             nack_err_ff;
    logic             scl_oe_b_ff;
    logic             sda_oe_b_ff;
    logic [1:0]       pins_s;
    logic             scl_s;
    logic             sda_s;
    logic             scl_want;
    logic             sda_want;
    logic             bit_lvl;
    logic             is_byte;
    logic             is_rd;
    logic             is_tx;
    logic             tick;
    logic             hold;
    logic             stretch;
    logic             run;
    logic             slot_end;
    logic             sample;
    logic             byte_end;
    logic             nack;
    logic             take;
    logic             wr_take;

    rpm_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
        .clk   (ref_clk),
        .rst_b (rst_b),
        .d     ({scl_i, sda_i}),
        .q     (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Both lines are open drain: the level is only ever pulled low.
    assign scl_o     = 1'h0;
    assign sda_o     = 1'h0;
    assign scl_oe_b  = scl_oe_b_ff;
    assign sda_oe_b  = sda_oe_b_ff;
    assign cmd_ready = cmd_ready_ff;
    assign wr_ready  = wr_ready_ff;
    assign rd_valid  = rd_valid_ff;
    assign rd_word   = rd_word_ff;
    assign done      = done_ff;
    assign nack_err  = nack_err_ff;

    assign is_byte  = is_byte_st(st_ff);
    assign is_rd    = is_rd_st(st_ff);
    assign is_tx    = is_byte && !is_rd;
    assign tick     = qcnt_ff == QW'(QTR - 1);
    // A write stalls with the clock low until the next word is supplied.
    assign hold     = st_ff == ST_WR_HI && bitn_ff == 4'h0 && ph_ff == PH_FALL
                      && !have_word_ff;
    // The rise phase waits until the line is really seen high.
    assign stretch  = ph_ff == PH_RISE && !scl_s;
    assign run      = st_ff != ST_IDLE && !hold && !stretch;
    assign slot_end = run && tick && ph_ff == PH_HIGH;
    assign sample   = run && tick && ph_ff == PH_RISE;
    assign byte_end = slot_end && is_byte && bitn_ff == ACK_SLOT;
    assign nack     = is_tx && ack_ff;
    assign take     = st_ff == ST_IDLE && cmd_valid && cmd_ready_ff
                      && scl_s && sda_s;
    assign wr_take  = wr_valid && wr_ready_ff;

    always_comb begin
        if (bitn_ff != ACK_SLOT) begin
            bit_lvl = is_rd ? 1'h1 : txb_ff[7];
        end else if (st_ff == ST_RD_LO) begin
            bit_lvl = left_ff == NW_ONE;
        end else begin
            bit_lvl = !is_rd;
        end
    end

    // Line levels per quarter; data moves with the clock high only for a start, repeated start or stop.
    always_comb begin
        scl_want = 1'h1;
        sda_want = sda_oe_b_ff;
        case (st_ff)
            ST_IDLE: begin
                sda_want = 1'h1;
            end
            ST_START: begin
                sda_want = ph_ff != PH_HIGH;
            end
            ST_RSTART: begin
                scl_want = ph_ff[1];
                if (ph_ff != PH_FALL) begin
                    sda_want = ph_ff != PH_HIGH;
                end
            end
            ST_STOP: begin
                scl_want = ph_ff[1];
                if (ph_ff != PH_FALL) begin
                    sda_want = ph_ff == PH_HIGH;
                end
            end
            default: begin
                scl_want = ph_ff[1];
                if (ph_ff != PH_FALL) begin
                    sda_want = bit_lvl;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scl_oe_b_ff <= 1'h1;
            sda_oe_b_ff <= 1'h1;
        end else begin
            scl_oe_b_ff <= scl_want;
            sda_oe_b_ff <= sda_want;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || st_ff == ST_IDLE) begin
            qcnt_ff <= '0;
            ph_ff   <= PH_FALL;
        end else if (run) begin
            if (tick) begin
                qcnt_ff <= '0;
                ph_ff   <= ph_ff + 2'h1;
            end else begin
                qcnt_ff <= qcnt_ff + QW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bitn_ff <= 4'h0;
        end else if (slot_end) begin
            bitn_ff <= (is_byte && bitn_ff != ACK_SLOT) ? bitn_ff + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            txb_ff <= 8'hFF;
        end else if (ph_ff == PH_FALL && qcnt_ff == '0 && bitn_ff == 4'h0) begin
            txb_ff <= byte_of(st_ff, low_bit_ff, ptr_ff, word_ff);
        end else if (slot_end && bitn_ff != ACK_SLOT) begin
            txb_ff <= {txb_ff[6:0], 1'h1};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rxb_ff <= 8'h00;
            ack_ff <= 1'h1;
        end else if (sample) begin
            if (bitn_ff == ACK_SLOT) begin
                ack_ff <= sda_s;
            end else begin
                rxb_ff <= {rxb_ff[6:0], sda_s};
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_st = ST_START;
                end
            end
            ST_START: begin
                if (slot_end) begin
                    nxt_st = ST_ADDR_W;
                end
            end
            ST_RSTART: begin
                if (slot_end) begin
                    nxt_st = ST_ADDR_R;
                end
            end
            ST_STOP: begin
                if (slot_end) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: begin
                if (byte_end) begin
                    if (nack) begin
                        nxt_st = ST_STOP;
                    end else begin
                        case (st_ff)
                            ST_ADDR_W: nxt_st = ST_REG;
                            ST_REG:    nxt_st = left_ff == '0 ? ST_STOP
                                              : rd_ff ? ST_RSTART : ST_WR_HI;
                            ST_ADDR_R: nxt_st = ST_RD_HI;
                            ST_WR_HI:  nxt_st = ST_WR_LO;
                            ST_RD_HI:  nxt_st = ST_RD_LO;
                            default:   nxt_st = left_ff == NW_ONE ? ST_STOP
                                              : is_rd ? ST_RD_HI : ST_WR_HI;
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ptr_ff     <= 8'h00;
            left_ff    <= '0;
            rd_ff      <= 1'h0;
            low_bit_ff <= 1'h0;
        end else if (take) begin
            ptr_ff     <= cmd.reg_addr;
            left_ff    <= cmd.nwords;
            rd_ff      <= cmd.rd;
            low_bit_ff <= slave_addr_low_bit;
        end else if (byte_end && !nack && st_ff inside {ST_WR_LO, ST_RD_LO}) begin
            ptr_ff  <= ptr_ff + PTR_STEP;
            left_ff <= left_ff - NW_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            word_ff      <= '0;
            have_word_ff <= 1'h0;
        end else if (wr_take) begin
            word_ff      <= wr_data;
            have_word_ff <= 1'h1;
        end else if (byte_end && st_ff == ST_RD_HI) begin
            word_ff[15:8] <= rxb_ff;
        end else if ((byte_end && st_ff == ST_WR_LO) || st_ff == ST_IDLE) begin
            have_word_ff <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cmd_ready_ff <= 1'h0;
            wr_ready_ff  <= 1'h0;
        end else begin
            cmd_ready_ff <= nxt_st == ST_IDLE;
            wr_ready_ff  <= !rd_ff && !have_word_ff && left_ff != '0 && !wr_take
                            && !(st_ff inside {ST_IDLE, ST_STOP})
                            && !(byte_end && st_ff == ST_WR_LO);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_valid_ff <= 1'h0;
            rd_word_ff  <= '0;
        end else begin
            rd_valid_ff <= byte_end && st_ff == ST_RD_LO;
            if (byte_end && st_ff == ST_RD_LO) begin
                rd_word_ff <= '{reg_addr: ptr_ff, data: {word_ff[15:8], rxb_ff}};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            err_ff      <= 1'h0;
            done_ff     <= 1'h0;
            nack_err_ff <= 1'h0;
        end else begin
            done_ff <= st_ff == ST_STOP && slot_end;
            if (take) begin
                err_ff <= 1'h0;
            end else if (byte_end && nack) begin
                err_ff <= 1'h1;
            end
            if (st_ff == ST_STOP && slot_end) begin
                nack_err_ff <= err_ff;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_data_stable_high:
        assert property (is_byte && $past(is_byte_st(st_ff)) && $past(is_byte_st(st_ff), 2)
                         && scl_oe_b_ff && $past(scl_oe_b_ff) |-> $stable(sda_oe_b_ff))
        else $error("Data moved while the clock was high.");
    a_start_edge:
        assert property ($fell(sda_oe_b_ff) && scl_oe_b_ff
                         |-> $past(st_ff) inside {ST_START, ST_RSTART})
        else $error("Data fell with clock high outside a start.");
    a_stop_edge:
        assert property ($rose(sda_oe_b_ff) && scl_oe_b_ff |-> $past(st_ff) == ST_STOP)
        else $error("Data rose with clock high outside a stop.");
    a_ack_release:
        assert property (is_tx && bitn_ff == ACK_SLOT && ph_ff == PH_HIGH |-> sda_oe_b_ff)
        else $error("Master held data during the slave acknowledge.");
    a_read_release:
        assert property (is_rd && bitn_ff != ACK_SLOT && ph_ff == PH_HIGH |-> sda_oe_b_ff)
        else $error("Master drove data while the slave sends.");
    a_read_ack_level:
        assert property (is_rd && bitn_ff == ACK_SLOT && ph_ff == PH_HIGH
                         |-> sda_oe_b_ff == (st_ff == ST_RD_LO && left_ff == NW_ONE))
        else $error("Wrong acknowledge level on a read byte.");
    a_addr_write:
        assert property (st_ff == ST_ADDR_W && bitn_ff == 4'h0 && ph_ff == PH_SET
                         |-> txb_ff == {DEV_ADDR_HI, low_bit_ff, RW_WR})
        else $error("Wrong write address byte.");
    a_addr_read:
        assert property (st_ff == ST_ADDR_R && bitn_ff == 4'h0 && ph_ff == PH_SET
                         |-> txb_ff == {DEV_ADDR_HI, low_bit_ff, RW_RD})
        else $error("Wrong read address byte.");
    a_nack_abort:
        assert property (byte_end && nack |=> st_ff == ST_STOP && err_ff)
        else $error("Missing acknowledge did not end the transfer.");
    a_ptr_step:
        assert property (byte_end && !nack && st_ff == ST_WR_LO
                         |=> ptr_ff == $past(ptr_ff) + PTR_STEP)
        else $error("Pointer did not step after a pair.");
    a_rd_pulse:
        assert property (byte_end && st_ff == ST_RD_LO |=> rd_valid_ff ##1 !rd_valid_ff)
        else $error("Read word was not a single pulse.");
    a_idle_lines:
        assert property (st_ff == ST_IDLE && $past(st_ff) == ST_IDLE
                         |-> scl_oe_b_ff && sda_oe_b_ff)
        else $error("Lines not released while idle.");
endmodule // rpm_master

// >>> verification/rpm_codec_model.sv
// Behavioural model of the codec's two-wire slave port and its register file.
// Assumes resolved lines with pull-ups; it only ever pulls the data line low.
`timescale 1ns/1ps
module rpm_codec_model (
    // Serial lines.
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_drv_b,
    // Strap.
    input  wire logic addr_select_pin
);
    logic [15:0] regs [256];
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic [7:0]  tx_b;
    logic [7:0]  hi_b;
    logic [3:0]  cnt;
    logic [1:0]  ph; // 0 address, 1 pointer, 2 data, 3 ignoring the bus.
    logic        tx;
    logic        hi;
    logic        mack;
    logic        scl_q;

    // One process owns every variable; the last clock level tells the edges apart.
    initial begin
        sda_drv_b = 1'b1;
        ph = 2'h3;
        cnt = 4'h0;
        tx = 1'b0;
        hi = 1'b1;
        mack = 1'b0;
        ptr = 8'h00;
        scl_q = 1'b1;
        for (int i = 0; i < 256; i++) regs[i] = 16'hA500 ^ 16'(i);
        forever begin
            @(scl or sda);
            if (scl === 1'b1 && scl_q === 1'b1) begin
                tx = 1'b0;
                sda_drv_b = 1'b1;
                if (sda === 1'b0) begin
                    cnt = 4'h0;
                    ph = 2'h0;
                end else begin
                    ph = 2'h3;
                end
            end else if (scl === 1'b1) begin
                if (cnt < 4'h8) sh = {sh[6:0], sda};
                else mack = ~sda;
                cnt = cnt + 4'h1;
            end else if (scl_q === 1'b1) begin
                on_fall();
            end
            scl_q = scl;
        end
    end

    // Data changes only while the clock is low, so it never fakes a condition.
    task automatic on_fall();
        if (ph == 2'h3) begin
            sda_drv_b = 1'b1;
        end else if (cnt == 4'h8 && tx) begin
            sda_drv_b = 1'b1;
        end else if (cnt == 4'h8) begin
            sda_drv_b = 1'b0;
            if (ph == 2'h0) begin
                if (sh[7:1] == {6'h0D, addr_select_pin}) begin
                    tx = sh[0];
                    ph = sh[0] ? 2'h2 : 2'h1;
                    hi = 1'b1;
                end else begin
                    ph = 2'h3;
                    sda_drv_b = 1'b1;
                end
            end else if (ph == 2'h1) begin
                ptr = sh;
                ph = 2'h2;
            end else if (hi) begin
                hi_b = sh;
                hi = 1'b0;
            end else begin
                regs[ptr] = {hi_b, sh};
                ptr = ptr + 8'h01;
                hi = 1'b1;
            end
        end else if (cnt == 4'h9) begin
            cnt = 4'h0;
            sda_drv_b = 1'b1;
            if (tx && !mack) ph = 2'h3;
            if (tx && mack) begin
                tx_b = hi ? regs[ptr][15:8] : regs[ptr][7:0];
                if (!hi) ptr = ptr + 8'h01;
                hi = ~hi;
                sda_drv_b = tx_b[7];
            end
        end else if (tx) begin
            sda_drv_b = tx_b[3'(4'h7 - cnt)];
        end
    endtask
endmodule // rpm_codec_model

// >>> verification/tb.sv
// Self-checking bench: master against the codec model on a pulled-up bus.
// Assumes the master derives its serial clock from ref_clk.
`timescale 1ns/1ps
module tb;
    import rpm_pkg::*;
    localparam int unsigned QTR_T = 4;
    logic       ref_clk = 1'b0;
    logic       rst_b, cmd_valid, lb, sel, wr_valid;
    logic       cmd_ready, wr_ready, rd_valid, done, nack_err;
    logic       scl_o, scl_oe_b, sda_o, sda_oe_b, drv_b, scl_w, sda_w, last_ack, mon_scl_q;
    logic [15:0] wr_data;
    logic [15:0] wq [4];
    logic [7:0] mon_sh, first_byte;
    rpm_cmd_s   cmd;
    rpm_rsp_s   rd_word;
    rpm_rsp_s   rq [4];
    int         fails, n_compared, nrd, mon_cnt, mon_idx;

    // Only the master may pull the clock; the pull-up wins otherwise.
    assign scl_w = scl_oe_b | scl_o;
    assign sda_w = (sda_oe_b | sda_o) & drv_b;

    rpm_master #(.QTR(QTR_T)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd(cmd), .slave_addr_low_bit(lb), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_word(rd_word),
        .done(done), .nack_err(nack_err), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_b(scl_oe_b), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b(sda_oe_b));
    rpm_codec_model slave (.scl(scl_w), .sda(sda_w), .sda_drv_b(drv_b),
        .addr_select_pin(sel));

    always #5 ref_clk = ~ref_clk;

    // Wire monitor: first byte after each start and the last ack bit seen.
    initial begin
        mon_scl_q = 1'b1;
        forever begin
            @(scl_w or negedge sda_w);
            if (scl_w === 1'b1 && mon_scl_q === 1'b1) begin
                mon_cnt = 0;
                mon_idx = 0;
            end else if (scl_w === 1'b1) begin
                if (mon_cnt < 8) mon_sh = {mon_sh[6:0], sda_w};
                if (mon_cnt == 8) last_ack = sda_w;
                mon_cnt++;
                if (mon_cnt == 8 && mon_idx == 0) first_byte = mon_sh;
                if (mon_cnt == 8) mon_idx++;
                if (mon_cnt == 9) mon_cnt = 0;
            end
            mon_scl_q = scl_w;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_cmd(input logic rd, input logic [7:0] ra, input logic [3:0] nw,
                          input logic lo);
        int k;
        int w;
        k = 0;
        w = 0;
        nrd = 0;
        // An edge passes first, so the previous call's releases are seen.
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{rd: rd, reg_addr: ra, nwords: nw};
        lb <= lo;
        wr_valid <= (!rd && nw != 4'h0);
        wr_data <= wq[0];
        do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++k < 100);
        cmd_valid <= 1'b0;
        while (k < 20000) begin
            @(posedge ref_clk);
            k++;
            if (wr_valid && wr_ready === 1'b1) begin
                w++;
                wr_valid <= (w < int'(nw));
                wr_data <= wq[w % 4];
            end
            if (rd_valid === 1'b1 && nrd < 4) begin
                rq[nrd] = rd_word;
                nrd++;
            end
            if (done === 1'b1) break;
        end
        wr_valid <= 1'b0;
        check("command done", 32'(done), 32'h1);
    endtask

    task automatic t_write();
        for (int s = 0; s < 2; s++) begin
            sel = 1'(s);
            wq[0] = 16'hC3A0 + 16'(s);
            wq[1] = 16'h5A0F - 16'(s);
            do_cmd(1'b0, 8'h7F, 4'h2, sel);
            check("write nack", 32'(nack_err), 32'h0);
            check("address byte", 32'(first_byte), {24'h0, 6'h0D, sel, 1'b0});
            check("reg 7F", 32'(slave.regs[8'h7F]), 32'(wq[0]));
            check("reg 80", 32'(slave.regs[8'h80]), 32'(wq[1]));
            check("idle lines", {30'h0, scl_w, sda_w}, 32'h3);
        end
    endtask

    task automatic t_read();
        logic [15:0] exp [3];
        exp[0] = 16'hA500 ^ 16'h007E;
        exp[1] = wq[0];
        exp[2] = wq[1];
        do_cmd(1'b1, 8'h7E, 4'h3, sel);
        check("read count", 32'(nrd), 32'h3);
        for (int i = 0; i < 3; i++) begin
            check("read pointer", 32'(rq[i].reg_addr), 32'(8'h7E + 8'(i)));
            check("read data", 32'(rq[i].data), 32'(exp[i]));
        end
        check("read address byte", 32'(first_byte), {24'h0, 6'h0D, sel, 1'b1});
        check("final ack bit", 32'(last_ack), 32'h1);
        check("read nack", 32'(nack_err), 32'h0);
    endtask

    task automatic t_mismatch();
        do_cmd(1'b0, 8'h10, 4'h1, ~sel);
        check("mismatch nack", 32'(nack_err), 32'h1);
        check("reg 10 kept", 32'(slave.regs[8'h10]), 32'h0000A510);
    endtask

    // A pointer-only write followed at once by a read of that register.
    task automatic t_back_to_back();
        do_cmd(1'b0, 8'h80, 4'h0, sel);
        check("pointer nack", 32'(nack_err), 32'h0);
        do_cmd(1'b1, 8'h80, 4'h1, sel);
        check("b2b data", 32'(rq[0].data), 32'(wq[1]));
        check("b2b pointer", 32'(rq[0].reg_addr), 32'h80);
    endtask

    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        fails++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        lb = 1'b0;
        sel = 1'b0;
        wr_valid = 1'b0;
        wr_data = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_write();
        t_read();
        t_mismatch();
        t_back_to_back();
        close_out();
    end
endmodule // tb
